// ### hdl/bridge_config_header_status.v
// upper part of the bridge type-1 header: status flags, ids, class and timers over apb
`timescale 1ns/1ns
`include "bridge_cfg_defines.vh"

// How it works
// - poisoned completion or write sets master_parity_flag bit 8 when parity reporting on
// - error message sent with system_error_enable sets sent_system_error bit 14
// - any poisoned packet on primary side sets detected_parity_flag bit 15
// - downstream ports also set bit 15 on internal switch parity error
// - legacy_irq_pending bit 3 always reads zero
// - forwarded downstream legacy interrupts never show in bit 3
// - cap_list_present bit 4 is hardwired to one
// - fast bus, back to back, select timing, abort bits read zero
// - class code reads interface 0x00, sub-class 0x04, base class 0x06
// - cache_line_size resets to zero, stores writes, steers nothing
// - header_type reads constant 0x01
// - primary_latency_timer is read-only zero
// - readable 8-bit revision_number, writes locked unless lock control bit 0 is set
// - parity_report_enable is command bit 6; clear means bit 8 never sets
// - system_error_enable is command bit 8; set means errors get reported
module bridge_config_header_status #(
  parameter [7:0] REVISION_DEFAULT = 8'h00,
  parameter DOWNSTREAM_PORT = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // primary side events, one-cycle pulses from core logic
  input wire poisoned_req_rx,
  input wire poisoned_tlp_rx,
  input wire error_msg_sent,
  input wire internal_parity_err,
  input wire forwarded_legacy_irq,
  // control outputs to core logic
  output reg parity_report_enable,
  output reg system_error_enable,
  output reg error_report_req,
  // interrupt
  output reg irq
);

  // apb decode
  function [9:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[11:2];
    end
  endfunction

  function is_mapped;
    input [9:0] idx;
    begin
      case (idx)
        `IDX_BRIDGE_COMMAND,
        `IDX_BRIDGE_STATUS,
        `IDX_REVISION_NUMBER,
        `IDX_CLASS_CODE,
        `IDX_CACHE_LINE_SIZE,
        `IDX_PRIMARY_LATENCY_TIMER,
        `IDX_HEADER_TYPE,
        `IDX_IRQ_STATUS,
        `IDX_IRQ_MASK,
        `IDX_LOCK_CONTROL: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  wire [9:0] idx;
  wire access_phase;
  wire wr_commit;
  wire wr_ok;

  assign idx = reg_index(paddr);
  // one wait state: pready rises in the second access cycle
  assign access_phase = psel & penable & ~pready;
  assign wr_commit = psel & penable & pready & pwrite;
  assign wr_ok = wr_commit & is_mapped(idx);

  // register state
  reg [7:0] cache_line_size_reg;
  reg [7:0] revision_number_reg;
  reg revision_unlock_reg;
  reg [`IRQ_COUNT-1:0] irq_mask_reg;
  reg parity_report_enable_next;
  reg system_error_enable_next;
  reg revision_loaded_reg;

  // status flag set terms
  wire master_parity_set;
  wire sent_system_error_set;
  wire detected_parity_set;
  wire [`IRQ_COUNT-1:0] event_set;
  wire [`IRQ_COUNT-1:0] status_clear;
  wire [`IRQ_COUNT-1:0] irq_clear;
  wire [`IRQ_COUNT-1:0] status_flags;
  wire [`IRQ_COUNT-1:0] irq_flags;

  assign master_parity_set = poisoned_req_rx & parity_report_enable;
  assign sent_system_error_set = error_msg_sent & system_error_enable;
  // set regardless of parity_report_enable
  assign detected_parity_set = poisoned_tlp_rx | poisoned_req_rx
    | (DOWNSTREAM_PORT & internal_parity_err);

  assign event_set[`IRQ_MASTER_PARITY] = master_parity_set;
  assign event_set[`IRQ_SYSTEM_ERROR] = sent_system_error_set;
  assign event_set[`IRQ_DETECTED_PARITY] = detected_parity_set;

  // write-one-to-clear strobes for status and irq flags
  assign status_clear[`IRQ_MASTER_PARITY] = wr_ok & (idx == `IDX_BRIDGE_STATUS)
    & pwdata[`STS_MASTER_PARITY_FLAG];
  assign status_clear[`IRQ_SYSTEM_ERROR] = wr_ok & (idx == `IDX_BRIDGE_STATUS)
    & pwdata[`STS_SENT_SYSTEM_ERROR];
  assign status_clear[`IRQ_DETECTED_PARITY] = wr_ok & (idx == `IDX_BRIDGE_STATUS)
    & pwdata[`STS_DETECTED_PARITY_FLAG];
  assign irq_clear = (wr_ok & (idx == `IDX_IRQ_STATUS)) ?
    pwdata[`IRQ_COUNT-1:0] : {`IRQ_COUNT{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `IRQ_COUNT; g = g + 1) begin : g_flags
      w1c_flag u_status_flag (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_pulse(event_set[g]),
        .clear_pulse(status_clear[g]),
        .flag_reg(status_flags[g])
      );
      w1c_flag u_irq_flag (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_pulse(event_set[g]),
        .clear_pulse(irq_clear[g]),
        .flag_reg(irq_flags[g])
      );
    end
  endgenerate

  // bridge_command: only the two enables are kept here
  always @* begin
    parity_report_enable_next = parity_report_enable;
    system_error_enable_next = system_error_enable;
    if (wr_ok && idx == `IDX_BRIDGE_COMMAND) begin
      parity_report_enable_next = pwdata[`CMD_PARITY_REPORT_ENABLE];
      system_error_enable_next = pwdata[`CMD_SYSTEM_ERROR_ENABLE];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      parity_report_enable <= 1'b0;
      system_error_enable <= 1'b0;
    end else begin
      parity_report_enable <= parity_report_enable_next;
      system_error_enable <= system_error_enable_next;
    end
  end

  // detected errors go out as a request to send an error message
  always @(posedge clk) begin
    if (sys_rst)
      error_report_req <= 1'b0;
    else
      error_report_req <= system_error_enable
        & (poisoned_tlp_rx | poisoned_req_rx | (DOWNSTREAM_PORT & internal_parity_err));
  end

  // cache_line_size has no effect on bridge operation
  always @(posedge clk) begin
    if (sys_rst)
      cache_line_size_reg <= `CACHE_LINE_SIZE_RST;
    else if (wr_ok && idx == `IDX_CACHE_LINE_SIZE)
      cache_line_size_reg <= pwdata[7:0];
  end

  // lock control: revision writes are refused unless unlocked
  always @(posedge clk) begin
    if (sys_rst)
      revision_unlock_reg <= 1'b0;
    else if (wr_ok && idx == `IDX_LOCK_CONTROL)
      revision_unlock_reg <= pwdata[`LOCK_REVISION_UNLOCK];
  end

  // revision loads its default one cycle after reset release
  always @(posedge clk) begin
    if (sys_rst)
      revision_loaded_reg <= 1'b0;
    else
      revision_loaded_reg <= 1'b1;
  end

  always @(posedge clk) begin
    if (sys_rst)
      revision_number_reg <= `ZERO_BYTE;
    else if (!revision_loaded_reg)
      revision_number_reg <= REVISION_DEFAULT;
    else if (wr_ok && idx == `IDX_REVISION_NUMBER && revision_unlock_reg)
      revision_number_reg <= pwdata[7:0];
  end

  // irq mask
  always @(posedge clk) begin
    if (sys_rst)
      irq_mask_reg <= {`IRQ_COUNT{1'b0}};
    else if (wr_ok && idx == `IDX_IRQ_MASK)
      irq_mask_reg <= pwdata[`IRQ_COUNT-1:0];
  end

  always @(posedge clk) begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irq_flags & irq_mask_reg);
  end

  // status word; forwarded legacy interrupts are deliberately not folded in
  wire unused_forwarded;
  reg [15:0] status_word;
  assign unused_forwarded = forwarded_legacy_irq;

  always @* begin
    status_word = 16'h0000;
    status_word[`STS_LEGACY_IRQ_PENDING] = 1'b0;
    status_word[`STS_CAP_LIST_PRESENT] = 1'b1;
    status_word[`STS_FAST_BUS_CAPABLE] = 1'b0;
    status_word[`STS_BACK_TO_BACK_OK] = 1'b0;
    status_word[`STS_SELECT_TIMING_HI:`STS_SELECT_TIMING_LO] = 2'b00;
    status_word[`STS_SENT_TARGET_ABORT] = 1'b0;
    status_word[`STS_GOT_TARGET_ABORT] = 1'b0;
    status_word[`STS_GOT_MASTER_ABORT] = 1'b0;
    status_word[`STS_MASTER_PARITY_FLAG] = status_flags[`IRQ_MASTER_PARITY];
    status_word[`STS_SENT_SYSTEM_ERROR] = status_flags[`IRQ_SYSTEM_ERROR];
    status_word[`STS_DETECTED_PARITY_FLAG] = status_flags[`IRQ_DETECTED_PARITY];
  end

  // read mux
  reg [31:0] read_word;

  always @* begin
    read_word = `ZERO_WORD;
    case (idx)
      `IDX_BRIDGE_COMMAND: begin
        read_word[`CMD_PARITY_REPORT_ENABLE] = parity_report_enable;
        read_word[`CMD_SYSTEM_ERROR_ENABLE] = system_error_enable;
      end
      `IDX_BRIDGE_STATUS: read_word[15:0] = status_word;
      `IDX_REVISION_NUMBER: read_word[7:0] = revision_number_reg;
      `IDX_CLASS_CODE: read_word[23:0] = {`BASE_CLASS_VAL, `SUB_CLASS_VAL,
        `PROGRAMMING_INTERFACE_VAL};
      `IDX_CACHE_LINE_SIZE: read_word[7:0] = cache_line_size_reg;
      `IDX_PRIMARY_LATENCY_TIMER: read_word[7:0] = `PRIMARY_LATENCY_TIMER_VAL;
      `IDX_HEADER_TYPE: read_word[7:0] = `HEADER_TYPE_VAL;
      `IDX_IRQ_STATUS: read_word[`IRQ_COUNT-1:0] = irq_flags;
      `IDX_IRQ_MASK: read_word[`IRQ_COUNT-1:0] = irq_mask_reg;
      `IDX_LOCK_CONTROL: read_word[`LOCK_REVISION_UNLOCK] = revision_unlock_reg;
      default: read_word = `ZERO_WORD;
    endcase
  end

  // apb answer: read data and error are captured with pready and held one cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= `ZERO_WORD;
      pslverr <= 1'b0;
    end else if (access_phase) begin
      pready <= 1'b1;
      pslverr <= ~is_mapped(idx);
      prdata <= (pwrite || !is_mapped(idx)) ? `ZERO_WORD : read_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `ZERO_WORD;
    end
  end

endmodule // bridge_config_header_status

// ### hdl/bridge_cfg_defines.vh
// register indices, field positions and fixed values of the bridge header upper part
`ifndef BRIDGE_CFG_DEFINES_VH
`define BRIDGE_CFG_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_BRIDGE_COMMAND 10'h004
`define IDX_BRIDGE_STATUS 10'h006
`define IDX_REVISION_NUMBER 10'h008
`define IDX_CLASS_CODE 10'h009
`define IDX_CACHE_LINE_SIZE 10'h00c
`define IDX_PRIMARY_LATENCY_TIMER 10'h00d
`define IDX_HEADER_TYPE 10'h00e
`define IDX_IRQ_STATUS 10'h040
`define IDX_IRQ_MASK 10'h041
`define IDX_LOCK_CONTROL 10'h042

// bridge_command fields
`define CMD_PARITY_REPORT_ENABLE 6
`define CMD_SYSTEM_ERROR_ENABLE 8

// bridge_status fields
`define STS_LEGACY_IRQ_PENDING 3
`define STS_CAP_LIST_PRESENT 4
`define STS_FAST_BUS_CAPABLE 5
`define STS_BACK_TO_BACK_OK 7
`define STS_MASTER_PARITY_FLAG 8
`define STS_SELECT_TIMING_LO 9
`define STS_SELECT_TIMING_HI 10
`define STS_SENT_TARGET_ABORT 11
`define STS_GOT_TARGET_ABORT 12
`define STS_GOT_MASTER_ABORT 13
`define STS_SENT_SYSTEM_ERROR 14
`define STS_DETECTED_PARITY_FLAG 15

// irq status / mask layout
`define IRQ_MASTER_PARITY 0
`define IRQ_SYSTEM_ERROR 1
`define IRQ_DETECTED_PARITY 2
`define IRQ_COUNT 3

// lock control field
`define LOCK_REVISION_UNLOCK 0

// fixed values
`define PROGRAMMING_INTERFACE_VAL 8'h00
`define SUB_CLASS_VAL 8'h04
`define BASE_CLASS_VAL 8'h06
`define CACHE_LINE_SIZE_RST 8'h00
`define PRIMARY_LATENCY_TIMER_VAL 8'h00
`define HEADER_TYPE_VAL 8'h01
`define ZERO_WORD 32'h0000_0000
`define ZERO_BYTE 8'h00

`endif

// ### hdl/w1c_flag.v
// sticky flag that hardware sets and software clears by writing one
`timescale 1ns/1ns
module w1c_flag (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // set and clear
  input wire set_pulse,
  input wire clear_pulse,
  // state
  output reg flag_reg
);

  reg flag_next;

  // a set in the same cycle as a clear wins, so no event is lost
  always @* begin
    flag_next = flag_reg;
    if (clear_pulse)
      flag_next = 1'b0;
    if (set_pulse)
      flag_next = 1'b1;
  end

  always @(posedge clk) begin
    if (sys_rst)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

endmodule // w1c_flag

// ### test/bridge_status_chk.sv
// port-level assertions for the bridge header status block
`timescale 1ns/1ns
`include "bridge_cfg_defines.vh"
module bridge_status_chk (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // error reporting
  input wire poisoned_req_rx,
  input wire poisoned_tlp_rx,
  input wire system_error_enable,
  input wire error_report_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire rd_ok = psel && penable && pready && !pwrite;
  wire [9:0] idx = paddr[11:2];
  status_fixed_a:
    assert property (rd_ok && idx == `IDX_BRIDGE_STATUS |->
      (prdata & 32'hffff_3eff) == 32'h0000_0010) else $error("status fixed bits wrong");
  class_read_a:
    assert property (rd_ok && idx == `IDX_CLASS_CODE |-> prdata == 32'h0006_0400)
      else $error("class code wrong");
  header_read_a:
    assert property (rd_ok && idx == `IDX_HEADER_TYPE |-> prdata == 32'h0000_0001)
      else $error("header type wrong");
  latency_read_a:
    assert property (rd_ok && idx == `IDX_PRIMARY_LATENCY_TIMER |-> prdata == 32'h0000_0000)
      else $error("latency timer not zero");
  err_report_a:
    assert property ((poisoned_req_rx || poisoned_tlp_rx) && system_error_enable
      |=> error_report_req) else $error("error report missing");
  pready_wait_a:
    assert property ($rose(psel && penable) |=> pready) else $error("pready late");
  pready_pulse_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  slverr_ready_a:
    assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
  rdata_idle_a:
    assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
endmodule // bridge_status_chk

bind bridge_config_header_status bridge_status_chk bridge_status_chk_i (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .poisoned_req_rx(poisoned_req_rx),
  .poisoned_tlp_rx(poisoned_tlp_rx), .system_error_enable(system_error_enable),
  .error_report_req(error_report_req));

// ### test/cfg_master.sv
// apb master standing in for the upstream configuration requester
`timescale 1ns/1ns
module cfg_master (
  // clock and request
  input wire clk,
  input wire start,
  input wire wr,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  // apb
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [11:0] paddr,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // result
  output reg done,
  output reg [31:0] rdata,
  output reg err
);
  initial begin
    {psel, penable, pwrite, done, err} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rdata = 32'h0000_0000;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    if (psel && penable && pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      done <= 1'b1;
      rdata <= prdata;
      err <= pslverr;
      // released lines must not keep looking valid
      paddr <= ~paddr;
      pwdata <= ~pwdata;
    end else if (psel) begin
      penable <= 1'b1;
    end else if (start) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
    end
  end
endmodule // cfg_master

// ### test/bridge_config_header_status_tb_top.sv
// self-checking bench for the bridge header status block
`timescale 1ns/1ns
`include "bridge_cfg_defines.vh"
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  n_errors = n_errors + 1; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module bridge_config_header_status_tb_top;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg start = 1'b0;
  reg wr = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [31:0] wdata = 32'h0000_0000;
  // req, tlp, msg, internal, forwarded
  reg [4:0] ev = 5'h00;
  wire psel, penable, pwrite, pready, pslverr, done, err, irq;
  wire parity_report_enable, system_error_enable, error_report_req;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata, rdata;
  integer n_errors = 0;
  integer cmp_count = 0;
  localparam [11:0] CMD = {`IDX_BRIDGE_COMMAND, 2'b00};
  localparam [11:0] STS = {`IDX_BRIDGE_STATUS, 2'b00};
  localparam [11:0] REV = {`IDX_REVISION_NUMBER, 2'b00};
  localparam [11:0] CCD = {`IDX_CLASS_CODE, 2'b00};
  localparam [11:0] CACHE_LINE_SIZE = {`IDX_CACHE_LINE_SIZE, 2'b00};
  localparam [11:0] LAT = {`IDX_PRIMARY_LATENCY_TIMER, 2'b00};
  localparam [11:0] HDR = {`IDX_HEADER_TYPE, 2'b00};
  localparam [11:0] IST = {`IDX_IRQ_STATUS, 2'b00};
  localparam [11:0] IMK = {`IDX_IRQ_MASK, 2'b00};
  localparam [11:0] LCK = {`IDX_LOCK_CONTROL, 2'b00};
  initial forever #25 clk = ~clk;
  cfg_master cfg_master_i (.clk(clk), .start(start), .wr(wr), .addr(addr), .wdata(wdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .done(done), .rdata(rdata), .err(err));
  // downstream port so the internal parity path is reachable
  // revision default is an arbitrary nonzero value so that its load can be seen
  bridge_config_header_status #(.REVISION_DEFAULT(8'h3c), .DOWNSTREAM_PORT(1'b1))
    bridge_config_header_status_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .poisoned_req_rx(ev[0]), .poisoned_tlp_rx(ev[1]),
    .error_msg_sent(ev[2]), .internal_parity_err(ev[3]), .forwarded_legacy_irq(ev[4]),
    .parity_report_enable(parity_report_enable), .system_error_enable(system_error_enable),
    .error_report_req(error_report_req), .irq(irq));
  task summarize;
    begin
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task acc(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      start <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20) begin
        n_errors = n_errors + 1;
        summarize;
      end
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input ee);
    begin
      acc(a, 1'b0, 32'h0000_0000);
      `CHK(rdata, e)
      `CHK(err, ee)
    end
  endtask
  task wrt(input [11:0] a, input [31:0] d);
    acc(a, 1'b1, d);
  endtask
  task pulse(input [4:0] v);
    begin
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 5'h00;
    end
  endtask
  task irq_is(input e);
    begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(irq, e)
    end
  endtask
  task t_ids;
    begin
      rd(CCD, 32'h0006_0400, 1'b0);
      wrt(CCD, 32'hffff_ffff);
      rd(CCD, 32'h0006_0400, 1'b0);
      wrt(HDR, 32'h0000_0000);
      rd(HDR, 32'h0000_0001, 1'b0);
      wrt(LAT, 32'h0000_00ff);
      rd(LAT, 32'h0000_0000, 1'b0);
      rd(STS, 32'h0000_0010, 1'b0);
      rd(CACHE_LINE_SIZE, 32'h0000_0000, 1'b0);
      wrt(CACHE_LINE_SIZE, 32'h0000_015a);
      rd(CACHE_LINE_SIZE, 32'h0000_005a, 1'b0);
      wrt(REV, 32'h0000_00a5);
      rd(REV, 32'h0000_003c, 1'b0);
      wrt(LCK, 32'h0000_0001);
      rd(LCK, 32'h0000_0001, 1'b0);
      wrt(REV, 32'h0000_00a5);
      rd(REV, 32'h0000_00a5, 1'b0);
      rd(12'h0fc, 32'h0000_0000, 1'b1);
      wrt(12'h0fc, 32'hffff_ffff);
      `CHK(err, 1'b1)
    end
  endtask
  task t_parity;
    begin
      pulse(5'h11);
      @(negedge clk);
      `CHK(error_report_req, 1'b0)
      rd(STS, 32'h0000_8010, 1'b0);
      wrt(STS, 32'h0000_8000);
      rd(STS, 32'h0000_0010, 1'b0);
      wrt(CMD, 32'h0000_0040);
      `CHK(parity_report_enable, 1'b1)
      `CHK(system_error_enable, 1'b0)
      pulse(5'h02);
      rd(STS, 32'h0000_8010, 1'b0);
      pulse(5'h01);
      rd(STS, 32'h0000_8110, 1'b0);
      wrt(STS, 32'h0000_ffff);
      rd(STS, 32'h0000_0010, 1'b0);
    end
  endtask
  task t_serr;
    begin
      pulse(5'h04);
      rd(STS, 32'h0000_0010, 1'b0);
      wrt(CMD, 32'h0000_0140);
      `CHK(system_error_enable, 1'b1)
      rd(CMD, 32'h0000_0140, 1'b0);
      pulse(5'h06);
      @(negedge clk);
      `CHK(error_report_req, 1'b1)
      rd(STS, 32'h0000_c010, 1'b0);
      wrt(STS, 32'h0000_c000);
      pulse(5'h08);
      rd(STS, 32'h0000_8010, 1'b0);
      wrt(STS, 32'h0000_8000);
    end
  endtask
  task t_irq;
    begin
      wrt(IST, 32'h0000_0007);
      wrt(IMK, 32'h0000_0000);
      pulse(5'h02);
      irq_is(1'b0);
      rd(IST, 32'h0000_0004, 1'b0);
      wrt(IMK, 32'h0000_0004);
      irq_is(1'b1);
      wrt(IST, 32'h0000_0004);
      irq_is(1'b0);
      pulse(5'h05);
      rd(IST, 32'h0000_0007, 1'b0);
      wrt(IST, 32'h0000_0007);
      rd(STS, 32'h0000_c110, 1'b0);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_ids;
    t_parity;
    t_serr;
    t_irq;
    summarize;
  end
endmodule // bridge_config_header_status_tb_top
